/* File: bench/strap_board.sv */
// Board strap pull resistors and drivers on the shared LED pins
`timescale 1ns/1ps
module strap_board (
   input  wire logic [5:0] i_strap,
   input  wire logic [5:0] i_oe,
   input  wire logic [5:0] i_out,
   output logic      [5:0] o_pin
);
   // Bit order: shift clk, serial out, port4, port3, port1, port0
   // Board level shows while the device listens, its own drive after
   // Select strap left at 1 by the board wherever the window is used
   always_comb o_pin = (i_oe & i_out) | (~i_oe & i_strap);
endmodule

/* File: bench/tb_strap_config_capture.sv */
// Self-checking bench for strap capture, LED polarity and APB status
`timescale 1ns/1ps
module tb_strap_config_capture;
   import strap_cfg_pkg::*;
   logic        clk, rst_b, psel, pen, pwr, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwd, prdata;
   logic [3:0]  on;
   logic [1:0]  drv, cs, sch;
   logic [5:0]  strap, pin, oe, out;
   logic [16:0] khz;
   logic        fwd, slv, eep, phy, vld;
   logic [36:0] dq[$];
   logic [32:0] rq[$];
   logic [31:0] seed;
   int          err_count, checked, vc;
   strap_board board (.i_strap(strap), .i_oe(oe), .i_out(out), .o_pin(pin));
   strap_config_capture uut (.I_CLK_SYS(clk), .I_RST_B(rst_b),
      .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
      .I_PWDATA(pwd), .O_PRDATA(prdata), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .I_PORT0_LED_C_ON(on[0]),
      .I_PORT1_LED_C_ON(on[1]), .I_PORT3_LED_C_ON(on[2]),
      .I_PORT4_LED_C_ON(on[3]), .I_LED_SHIFT_CLOCK_DRV(drv[1]),
      .I_LED_SERIAL_OUT_DRV(drv[0]), .I_PORT0_LED_C_PIN(pin[0]),
      .I_PORT1_LED_C_PIN(pin[1]), .I_PORT3_LED_C_PIN(pin[2]),
      .I_PORT4_LED_C_PIN(pin[3]), .I_LED_SERIAL_OUT_PIN(pin[4]),
      .I_LED_SHIFT_CLOCK_PIN(pin[5]), .O_PORT0_LED_C(out[0]),
      .O_PORT0_LED_C_OE(oe[0]), .O_PORT1_LED_C(out[1]),
      .O_PORT1_LED_C_OE(oe[1]), .O_PORT3_LED_C(out[2]),
      .O_PORT3_LED_C_OE(oe[2]), .O_PORT4_LED_C(out[3]),
      .O_PORT4_LED_C_OE(oe[3]), .O_LED_SERIAL_OUT(out[4]),
      .O_LED_SERIAL_OUT_OE(oe[4]), .O_LED_SHIFT_CLOCK(out[5]),
      .O_LED_SHIFT_CLOCK_OE(oe[5]), .O_CLOCK_SPEED_SELECT(cs),
      .O_CORE_CLK_KHZ(khz), .O_FWD_ENABLE(fwd), .O_SERIAL_SLAVE_EN(slv),
      .O_EEPROM_EN(eep), .O_LED_SCHEME_SELECT(sch),
      .O_INDIRECT_PHY_OK(phy), .O_STRAPS_VALID(vld));
   always #50 clk = ~clk;
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [16:0] kz(input logic [1:0] c);
      return c == 2'h0 ? KHZ_71M : c == 2'h1 ? KHZ_76M :
             c == 2'h2 ? KHZ_50M : KHZ_66M;
   endfunction
   task automatic chk(input string nm, input logic [36:0] e, g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   // Request held unchanged until pready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [32:0] e);
      @(posedge clk);
      psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwd <= d;
      if (!w) rq.push_back(e);
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (!pready) @(posedge clk);
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic close_out();
      if (dq.size() != 0 || rq.size() != 0) err_count++;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Results are compared as they appear, oldest note first
   always @(posedge clk) begin
      vc = vld ? vc + 1 : 0;
      if (vc == 2) chk("decode", dq.pop_front(), {cs, khz, fwd, slv, eep, sch, phy, out, oe});
      if (pready && !pwr) chk("read", rq.pop_front(), {4'h0, pslverr, prdata});
   end
   initial begin
      repeat (3000) @(posedge clk);
      err_count++;
      close_out();
   end
   initial begin
      logic [31:0] r;
      logic [5:0]  s;
      clk = 1'b0; rst_b = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0;
      paddr = 8'h0; pwd = 32'h0;
      on = 4'h0; drv = 2'h0; strap = 6'h3f; seed = 32'h498b5a52;
      err_count = 0; checked = 0; vc = 0;
      // Each pass resets mid-run; clock code walks all four values
      for (int i = 0; i < 8; i++) begin
         r = xs();
         s = {r[5:2], i[1:0]};
         strap <= s; on <= r[9:6]; drv <= r[11:10];
         rst_b <= 1'b0;
         repeat (4) @(posedge clk);
         rst_b <= 1'b1;
         dq.push_back({s[1:0], kz(s[1:0]), ~s[2], s[3], ~s[3], s[5:4], s[3],
                       r[11:10], s[3:0] ^ r[9:6], 6'h3f});
         repeat (4) @(posedge clk);
         // Board flips its strap pulls; latched values must not move
         strap <= ~s;
         apb(1'b0, ADDR_STRAP_STATUS, 32'h0, {25'h1, 2'h0, s});
         apb(1'b0, ADDR_CORE_CLOCK_SPEED_SELECT, 32'h0, {16'h0, kz(s[1:0])});
         apb(1'b0, 8'h0c, 32'h0, {1'b1, 32'h0});
         apb(1'b1, ADDR_FWD_CTRL, 32'h1, 33'h0);
         repeat (2) @(posedge clk);
         chk("fwd", 37'h1, {36'h0, fwd});
         apb(1'b0, ADDR_FWD_CTRL, 32'h0, {1'b0, 32'h1});
         $display("test %0d done", i);
      end
      repeat (2) @(posedge clk);
      close_out();
   end
endmodule

/* File: rtl/strap_cfg_pkg.sv */
// Constants for the power-up strap capture block
package strap_cfg_pkg;
   localparam int          ADDR_W            = 8;
   localparam logic [7:0]  ADDR_STRAP_STATUS = 8'h00;
   localparam logic [7:0]  ADDR_CORE_CLOCK_SPEED_SELECT    = 8'h04;
   localparam logic [7:0]  ADDR_FWD_CTRL     = 8'h08;
   localparam int          STS_CLK_LSB       = 0;
   localparam int          STS_HOLD_BIT      = 2;
   localparam int          STS_HOST_BIT      = 3;
   localparam int          STS_LED_LSB       = 4;
   localparam int          STS_VALID_BIT     = 8;
   localparam int          CTRL_FWD_GO_BIT   = 0;
   localparam logic [1:0]  CLK_SEL_71M       = 2'h0;
   localparam logic [1:0]  CLK_SEL_76M       = 2'h1;
   localparam logic [1:0]  CLK_SEL_50M       = 2'h2;
   localparam logic [1:0]  CLK_SEL_66M       = 2'h3;
   localparam logic [16:0] KHZ_71M           = 17'h116fc;
   localparam logic [16:0] KHZ_76M           = 17'h128e0;
   localparam logic [16:0] KHZ_50M           = 17'h0c350;
   localparam logic [16:0] KHZ_66M           = 17'h101d0;
   localparam logic [1:0]  CLK_SEL_RESET     = CLK_SEL_66M;
   localparam logic [1:0]  LED_SCHEME_RESET  = 2'h0;
   localparam logic        HOLD_RESET        = 1'b0;
   localparam logic        HOST_RESET        = 1'b0;
   localparam logic        FWD_GO_RESET      = 1'b0;
   localparam logic [3:0]  LED_POL_RESET     = 4'h0;
   typedef enum logic {PH_SAMPLE, PH_RUN} phase_type;
endpackage

/* File: rtl/strap_config_capture.sv */
// Strap capture, decode, shared LED pin drive and APB status slave
// How it works
// - Clock code 00 71.42, 01 76 MHz
// - Clock code 10 50, 11 66 MHz default
// - Hold strap 1 keeps forwarding off until software writes the go bit
// - Hold strap 0 forwards right after reset
// - Select 0 gives serial pins to EEPROM
// - Select 1 makes serial slave port
// - Indirect PHY window needs select 1
// - Scheme bits from shift clock, serial data
// - Clock bits share port1, port0 LED pins
// - Shared LED active level inverts strap
// - Select on port4, hold on port3 LED
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
module strap_config_capture (
   input  wire logic                           I_CLK_SYS,
   input  wire logic                           I_RST_B,
   input  wire logic                           I_PSEL,
   input  wire logic                           I_PENABLE,
   input  wire logic                           I_PWRITE,
   input  wire logic [strap_cfg_pkg::ADDR_W-1:0] I_PADDR,
   input  wire logic [31:0]                    I_PWDATA,
   output logic      [31:0]                    O_PRDATA,
   output logic                                O_PREADY,
   output logic                                O_PSLVERR,
   input  wire logic                           I_PORT0_LED_C_ON,
   input  wire logic                           I_PORT1_LED_C_ON,
   input  wire logic                           I_PORT3_LED_C_ON,
   input  wire logic                           I_PORT4_LED_C_ON,
   input  wire logic                           I_LED_SHIFT_CLOCK_DRV,
   input  wire logic                           I_LED_SERIAL_OUT_DRV,
   input  wire logic                           I_PORT0_LED_C_PIN,
   input  wire logic                           I_PORT1_LED_C_PIN,
   input  wire logic                           I_PORT3_LED_C_PIN,
   input  wire logic                           I_PORT4_LED_C_PIN,
   input  wire logic                           I_LED_SHIFT_CLOCK_PIN,
   input  wire logic                           I_LED_SERIAL_OUT_PIN,
   output logic                                O_PORT0_LED_C,
   output logic                                O_PORT0_LED_C_OE,
   output logic                                O_PORT1_LED_C,
   output logic                                O_PORT1_LED_C_OE,
   output logic                                O_PORT3_LED_C,
   output logic                                O_PORT3_LED_C_OE,
   output logic                                O_PORT4_LED_C,
   output logic                                O_PORT4_LED_C_OE,
   output logic                                O_LED_SHIFT_CLOCK,
   output logic                                O_LED_SHIFT_CLOCK_OE,
   output logic                                O_LED_SERIAL_OUT,
   output logic                                O_LED_SERIAL_OUT_OE,
   output logic      [1:0]                     O_CLOCK_SPEED_SELECT,
   output logic      [16:0]                    O_CORE_CLK_KHZ,
   output logic                                O_FWD_ENABLE,
   output logic                                O_SERIAL_SLAVE_EN,
   output logic                                O_EEPROM_EN,
   output logic      [1:0]                     O_LED_SCHEME_SELECT,
   output logic                                O_INDIRECT_PHY_OK,
   output logic                                O_STRAPS_VALID
);
   import strap_cfg_pkg::*;

   phase_type   phase_ff;
   logic [1:0]  clk_sel_ff;
   logic        fwd_hold_ff;
   logic        host_sel_ff;
   logic [1:0]  led_scheme_ff;
   logic [3:0]  led_pol_ff;
   logic        fwd_go_ff;
   logic [16:0] khz_ff;
   logic        fwd_en_ff;
   logic        slave_en_ff;
   logic        eeprom_en_ff;
   logic        phy_ok_ff;
   logic [3:0]  led_pin_ff;
   logic        ser_clk_ff;
   logic        ser_dat_ff;
   logic        oe_ff;
   logic [31:0] prdata_ff;
   logic        pready_ff;
   logic        pslverr_ff;
   logic [3:0]  led_pins;
   logic [3:0]  led_on;
   logic [16:0] nxt_khz;
   logic        setup;
   logic        wr_done;
   logic        addr_ok;
   logic [31:0] rd_mux;

   // Index order: {port4, port3, port1, port0}
   assign led_pins = {I_PORT4_LED_C_PIN, I_PORT3_LED_C_PIN,
                      I_PORT1_LED_C_PIN, I_PORT0_LED_C_PIN};
   assign led_on   = {I_PORT4_LED_C_ON, I_PORT3_LED_C_ON,
                      I_PORT1_LED_C_ON, I_PORT0_LED_C_ON};

   // Straps are caught on the first edge after release, since an
   // async reset may only load constants
   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         phase_ff <= PH_SAMPLE;
      end else begin
         phase_ff <= PH_RUN;
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         clk_sel_ff    <= CLK_SEL_RESET;
         fwd_hold_ff   <= HOLD_RESET;
         host_sel_ff   <= HOST_RESET;
         led_scheme_ff <= LED_SCHEME_RESET;
         led_pol_ff    <= LED_POL_RESET;
      end else if (phase_ff == PH_SAMPLE) begin
         clk_sel_ff    <= led_pins[1:0];
         fwd_hold_ff   <= led_pins[2];
         host_sel_ff   <= led_pins[3];
         led_scheme_ff <= {I_LED_SHIFT_CLOCK_PIN,
                           I_LED_SERIAL_OUT_PIN};
         led_pol_ff    <= led_pins;
      end
   end

   always_comb begin
      nxt_khz = KHZ_66M;
      unique case (clk_sel_ff)
         CLK_SEL_71M: nxt_khz = KHZ_71M;
         CLK_SEL_76M: nxt_khz = KHZ_76M;
         CLK_SEL_50M: nxt_khz = KHZ_50M;
         CLK_SEL_66M: nxt_khz = KHZ_66M;
      endcase
   end

   // Decoded enables stay inactive until the straps are held; khz_ff is not gated
   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         khz_ff       <= KHZ_66M;
         fwd_en_ff    <= 1'b0;
         slave_en_ff  <= 1'b0;
         eeprom_en_ff <= 1'b0;
         phy_ok_ff    <= 1'b0;
      end else begin
         khz_ff       <= nxt_khz;
         fwd_en_ff    <= (phase_ff == PH_RUN) &&
                         (!fwd_hold_ff || fwd_go_ff);
         slave_en_ff  <= (phase_ff == PH_RUN) && host_sel_ff;
         eeprom_en_ff <= (phase_ff == PH_RUN) && !host_sel_ff;
         phy_ok_ff    <= (phase_ff == PH_RUN) && host_sel_ff;
      end
   end

   // Pins stay released while sampling so the board pulls win
   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         led_pin_ff <= 4'h0;
         ser_clk_ff <= 1'b0;
         ser_dat_ff <= 1'b0;
         oe_ff      <= 1'b0;
      end else begin
         led_pin_ff <= led_on ^ led_pol_ff;
         ser_clk_ff <= I_LED_SHIFT_CLOCK_DRV;
         ser_dat_ff <= I_LED_SERIAL_OUT_DRV;
         oe_ff      <= (phase_ff == PH_RUN);
      end
   end

   // APB slave: zero wait states, pready raised in the access cycle
   assign setup   = I_PSEL && !I_PENABLE;
   assign wr_done = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
   assign addr_ok = (I_PADDR == ADDR_STRAP_STATUS) ||
                    (I_PADDR == ADDR_CORE_CLOCK_SPEED_SELECT) ||
                    (I_PADDR == ADDR_FWD_CTRL);

   always_comb begin
      rd_mux = 32'h0;
      if (I_PADDR == ADDR_STRAP_STATUS) begin
         rd_mux[STS_CLK_LSB +: 2] = clk_sel_ff;
         rd_mux[STS_HOLD_BIT]     = fwd_hold_ff;
         rd_mux[STS_HOST_BIT]     = host_sel_ff;
         rd_mux[STS_LED_LSB +: 2] = led_scheme_ff;
         rd_mux[STS_VALID_BIT]    = (phase_ff == PH_RUN);
      end else if (I_PADDR == ADDR_CORE_CLOCK_SPEED_SELECT) begin
         rd_mux[16:0] = khz_ff;
      end else if (I_PADDR == ADDR_FWD_CTRL) begin
         rd_mux[CTRL_FWD_GO_BIT] = fwd_go_ff;
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         prdata_ff  <= 32'h0;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff  <= setup;
         pslverr_ff <= setup && !addr_ok;
         if (setup && !I_PWRITE) begin
            prdata_ff <= rd_mux;
         end else if (!I_PSEL) begin
            prdata_ff <= 32'h0;
         end
      end
   end

   // Software releases a held switch once spanning tree is ready
   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         fwd_go_ff <= FWD_GO_RESET;
      end else if (wr_done && I_PADDR == ADDR_FWD_CTRL) begin
         fwd_go_ff <= I_PWDATA[CTRL_FWD_GO_BIT];
      end
   end

   assign O_PRDATA             = prdata_ff;
   assign O_PREADY             = pready_ff;
   assign O_PSLVERR            = pslverr_ff;
   assign O_PORT0_LED_C        = led_pin_ff[0];
   assign O_PORT1_LED_C        = led_pin_ff[1];
   assign O_PORT3_LED_C        = led_pin_ff[2];
   assign O_PORT4_LED_C        = led_pin_ff[3];
   assign O_PORT0_LED_C_OE     = oe_ff;
   assign O_PORT1_LED_C_OE     = oe_ff;
   assign O_PORT3_LED_C_OE     = oe_ff;
   assign O_PORT4_LED_C_OE     = oe_ff;
   assign O_LED_SHIFT_CLOCK    = ser_clk_ff;
   assign O_LED_SHIFT_CLOCK_OE = oe_ff;
   assign O_LED_SERIAL_OUT     = ser_dat_ff;
   assign O_LED_SERIAL_OUT_OE  = oe_ff;
   assign O_CLOCK_SPEED_SELECT = clk_sel_ff;
   assign O_CORE_CLK_KHZ       = khz_ff;
   assign O_FWD_ENABLE         = fwd_en_ff;
   assign O_SERIAL_SLAVE_EN    = slave_en_ff;
   assign O_EEPROM_EN          = eeprom_en_ff;
   assign O_LED_SCHEME_SELECT  = led_scheme_ff;
   assign O_INDIRECT_PHY_OK    = phy_ok_ff;
   assign O_STRAPS_VALID       = oe_ff;

   default clocking dflt_cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (!I_RST_B);

   chk_clock_speed_select_low: assert property (
      O_STRAPS_VALID && !O_CLOCK_SPEED_SELECT[1] |->
      O_CORE_CLK_KHZ == (O_CLOCK_SPEED_SELECT[0] ? KHZ_76M : KHZ_71M))
      else $error("Clock code 0x decoded wrong");

   chk_clock_speed_select_high: assert property (
      O_STRAPS_VALID && O_CLOCK_SPEED_SELECT[1] |->
      O_CORE_CLK_KHZ == (O_CLOCK_SPEED_SELECT[0] ? KHZ_66M : KHZ_50M))
      else $error("Clock code 1x decoded wrong");

   chk_hold_blocks: assert property (
      O_STRAPS_VALID && fwd_hold_ff && !fwd_go_ff |=> !O_FWD_ENABLE)
      else $error("Forwarding began while held");

   chk_fwd_free: assert property (
      $rose(O_STRAPS_VALID) && !fwd_hold_ff |-> O_FWD_ENABLE)
      else $error("Forwarding late with hold strap low");

   chk_eeprom_mode: assert property (
      O_STRAPS_VALID && !host_sel_ff |->
      O_EEPROM_EN && !O_SERIAL_SLAVE_EN)
      else $error("Serial pins not given to EEPROM");

   chk_slave_mode: assert property (
      O_STRAPS_VALID && host_sel_ff |->
      O_SERIAL_SLAVE_EN && !O_EEPROM_EN)
      else $error("Serial slave port not enabled");

   chk_phy_window: assert property (
      O_INDIRECT_PHY_OK == (O_STRAPS_VALID && O_SERIAL_SLAVE_EN))
      else $error("PHY window flag disagrees with select");

   chk_scheme_pins: assert property (
      phase_ff == PH_SAMPLE |=> O_LED_SCHEME_SELECT ==
      $past({I_LED_SHIFT_CLOCK_PIN, I_LED_SERIAL_OUT_PIN}))
      else $error("LED scheme not taken from serial pins");

   chk_clk_pins: assert property (
      phase_ff == PH_SAMPLE |=> O_CLOCK_SPEED_SELECT ==
      $past({I_PORT1_LED_C_PIN, I_PORT0_LED_C_PIN}))
      else $error("Clock code not taken from LED pins");

   chk_led_polarity: assert property (
      O_STRAPS_VALID |=> O_PORT0_LED_C_OE &&
      led_pin_ff == ($past(led_on) ^ led_pol_ff))
      else $error("Shared LED polarity wrong");

   chk_sel_pins: assert property (
      phase_ff == PH_SAMPLE |=>
      host_sel_ff == $past(I_PORT4_LED_C_PIN) &&
      fwd_hold_ff == $past(I_PORT3_LED_C_PIN))
      else $error("Select or hold strap on wrong pin");

   chk_straps_hold: assert property (
      O_STRAPS_VALID |=> $stable({clk_sel_ff, fwd_hold_ff,
      host_sel_ff, led_scheme_ff, led_pol_ff}) [*4])
      else $error("Latched strap changed before reset");

   cov_held_release: cover property (
      O_STRAPS_VALID && fwd_hold_ff ##[1:50] O_FWD_ENABLE);
   cov_eeprom_boot: cover property (O_EEPROM_EN);
   cov_bad_addr: cover property (O_PREADY && O_PSLVERR);
   cov_slow_clock: cover property (
      O_STRAPS_VALID && O_CLOCK_SPEED_SELECT == CLK_SEL_50M);
endmodule
